// [design/exposure_gain_status_regs_consts.vh]
// constants for the second exposure/frame-rate context and sequencer status bank
// assumes 9-bit word addresses on the serial configuration port and 16-bit registers
`ifndef EXPOSURE_GAIN_STATUS_REGS_CONSTS_VH
`define EXPOSURE_GAIN_STATUS_REGS_CONSTS_VH

// register word addresses
`define ADDR_FRAME_OR_RESET_PERIOD_CTX2 9'h0E7
`define ADDR_INTEGRATION_TIME_CTX2      9'h0E8
`define ADDR_SPARE_E9                   9'h0E9
`define ADDR_SPARE_EA                   9'h0EA
`define ADDR_ANALOG_GAIN_CTX2           9'h0EB
`define ADDR_POST_ADC_GAIN_CTX2         9'h0EC
`define ADDR_SPARE_ED                   9'h0ED
`define ADDR_SPARE_EE                   9'h0EE
`define ADDR_SPARE_EF                   9'h0EF
`define ADDR_COLUMN_COUNT_STATUS        9'h0F0
`define ADDR_ROW_COUNT_STATUS           9'h0F1
`define ADDR_TIME_UNIT_STATUS           9'h0F2
`define ADDR_RESET_PERIOD_STATUS        9'h0F3
`define ADDR_INTEGRATION_TIME_STATUS    9'h0F4
`define ADDR_INTEGRATION_TIME_B_STATUS  9'h0F5
`define ADDR_INTEGRATION_TIME_C_STATUS  9'h0F6
`define ADDR_ANALOG_GAIN_STATUS         9'h0F7

// reset values
`define RST_FRAME_OR_RESET_PERIOD_CTX2  16'h0000
`define RST_INTEGRATION_TIME_CTX2       16'h0000
`define RST_SPARE_E9                    16'h0000
`define RST_SPARE_EA                    16'h0000
`define RST_ANALOG_GAIN_CTX2            16'h01E3
`define RST_POST_ADC_GAIN_CTX2          16'h0080
`define RST_SPARE_ED                    16'h0000
`define RST_SPARE_EE                    16'hFFFF
`define RST_SPARE_EF                    16'h0000
`define RST_STATUS                      16'h0000
`define VAL_COLUMN_COUNT                16'h0050
`define VAL_ROW_COUNT                   16'h1400

// field positions
`define COL_GAIN_MSB                    4
`define COL_GAIN_LSB                    0
`define FE_GAIN_MSB                     12
`define FE_GAIN_LSB                     5
`define POST_ADC_GAIN_MSB               11

// period select encoding
`define PERIOD_IS_RESET                 1'b0
`define PERIOD_IS_FRAME                 1'b1

// serial frame layout: 9 address bits, 1 write bit, 16 data bits
`define SER_ADDR_LAST                   5'h08
`define SER_RW_BIT                      5'h09
`define SER_LAST_BIT                    5'h19

`endif

// [design/exposure_gain_status_regs.v]
// second exposure/frame-rate context, gain context and sequencer status words,
// reached over the serial configuration port, with the unit-based period timers.
// assumes sys_clk is the internal pll clock and sequencer inputs share that clock.
//
// Notes on behaviour
// - period field: reset when mode 0, frame when 1
// - period counted in time units, not cycles
// - integration time field, time units, resets zero
// - one time unit equals multiplier pll cycles
// - time unit status valid only master global shutter
// - reset period status frozen in slave mode
// - three integration status words frozen in slave
`timescale 1ns/10ps
`default_nettype none
`include "exposure_gain_status_regs_consts.vh"

module exposure_gain_status_regs (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // serial configuration port pins
  input  wire        spi_sck,
  input  wire        spi_ss_n,
  input  wire        spi_mosi,
  output wire        spi_miso,
  output wire        spi_miso_oe,
  // sequencer mode inputs
  input  wire        period_select_mode,
  input  wire [15:0] time_unit_mult,
  input  wire        master_mode,
  input  wire        global_shutter,
  input  wire        slave_mode,
  // sequencer timer starts
  input  wire        period_start,
  input  wire        integration_start,
  // sequencer current values
  input  wire [15:0] seq_reset_period,
  input  wire [15:0] seq_integration_time,
  input  wire [15:0] seq_integration_time_b,
  input  wire [15:0] seq_integration_time_c,
  input  wire [12:0] seq_analog_gain,
  // context settings
  output wire [15:0] frame_or_reset_period_ctx2,
  output wire [15:0] integration_time_ctx2,
  output wire [4:0]  column_amp_gain_ctx2,
  output wire [7:0]  frontend_amp_gain_ctx2,
  output wire [11:0] post_adc_gain_ctx2,
  // timer results
  output wire        period_busy,
  output wire        reset_period_end,
  output wire        frame_period_end,
  output wire        integration_busy,
  output wire        integration_end
);

  // serial port states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HEAD = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  // context and spare registers
  reg  [15:0] frp_ctx2_r;
  reg  [15:0] int_ctx2_r;
  reg  [15:0] gain_ctx2_r;
  reg  [15:0] post_gain_ctx2_r;
  reg  [15:0] spare_e9_r;
  reg  [15:0] spare_ea_r;
  reg  [15:0] spare_ed_r;
  reg  [15:0] spare_ee_r;
  reg  [15:0] spare_ef_r;
  // status words
  reg  [15:0] tu_stat_r;
  reg  [15:0] rp_stat_r;
  reg  [15:0] it_stat_r;
  reg  [15:0] itb_stat_r;
  reg  [15:0] itc_stat_r;
  reg  [12:0] gain_stat_r;
  // serial port state
  reg         sck_s1_r;
  reg         sck_s2_r;
  reg         sck_s3_r;
  reg         ss_s1_r;
  reg         ss_s2_r;
  reg         mosi_s1_r;
  reg         mosi_s2_r;
  reg  [1:0]  state_r;
  reg  [4:0]  bit_cnt_r;
  reg  [15:0] rx_r;
  reg  [15:0] tx_r;
  reg  [8:0]  addr_r;
  reg         wr_r;
  reg         miso_r;
  // timer plumbing
  reg         period_mode_r;
  wire [15:0] mult_eff;
  wire [1:0]  tmr_start;
  wire [31:0] tmr_len;
  wire [1:0]  tmr_busy;
  wire [1:0]  tmr_done;
  wire        sck_rise;
  wire        sck_fall;
  wire        frame_end;

  // read decode, used only by the read load into tx_r
  function [15:0] read_word;
    input [8:0] a;
    begin
      case (a)
        `ADDR_FRAME_OR_RESET_PERIOD_CTX2: read_word = frp_ctx2_r;
        `ADDR_INTEGRATION_TIME_CTX2:      read_word = int_ctx2_r;
        `ADDR_SPARE_E9:                   read_word = spare_e9_r;
        `ADDR_SPARE_EA:                   read_word = spare_ea_r;
        `ADDR_ANALOG_GAIN_CTX2:           read_word = gain_ctx2_r;
        `ADDR_POST_ADC_GAIN_CTX2:         read_word = post_gain_ctx2_r;
        `ADDR_SPARE_ED:                   read_word = spare_ed_r;
        `ADDR_SPARE_EE:                   read_word = spare_ee_r;
        `ADDR_SPARE_EF:                   read_word = spare_ef_r;
        `ADDR_COLUMN_COUNT_STATUS:        read_word = `VAL_COLUMN_COUNT;
        `ADDR_ROW_COUNT_STATUS:           read_word = `VAL_ROW_COUNT;
        `ADDR_TIME_UNIT_STATUS:           read_word = tu_stat_r;
        `ADDR_RESET_PERIOD_STATUS:        read_word = rp_stat_r;
        `ADDR_INTEGRATION_TIME_STATUS:    read_word = it_stat_r;
        `ADDR_INTEGRATION_TIME_B_STATUS:  read_word = itb_stat_r;
        `ADDR_INTEGRATION_TIME_C_STATUS:  read_word = itc_stat_r;
        `ADDR_ANALOG_GAIN_STATUS:         read_word = {3'h0, gain_stat_r};
        default:                          read_word = 16'h0000;
      endcase
    end
  endfunction

  // pin synchronisers, two flops before any logic
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      ss_s1_r   <= 1'b1;
      ss_s2_r   <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end else begin
      sck_s1_r  <= spi_sck;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      ss_s1_r   <= spi_ss_n;
      ss_s2_r   <= ss_s1_r;
      mosi_s1_r <= spi_mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  assign sck_rise  = sck_s2_r & ~sck_s3_r;
  assign sck_fall  = ~sck_s2_r & sck_s3_r;
  assign frame_end = sck_rise & (state_r == ST_DATA) & (bit_cnt_r == `SER_LAST_BIT);

  // serial frame: address, write flag, then 16 data bits, msb first
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      rx_r      <= 16'h0000;
      tx_r      <= 16'h0000;
      addr_r    <= 9'h000;
      wr_r      <= 1'b0;
      miso_r    <= 1'b0;
    end else if (ss_s2_r) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      miso_r    <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_r   <= ST_HEAD;
          bit_cnt_r <= 5'h00;
        end
        ST_HEAD: begin
          if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r <= `SER_ADDR_LAST) begin
              addr_r <= {addr_r[7:0], mosi_s2_r};
            end else begin
              wr_r    <= mosi_s2_r;
              tx_r    <= read_word(addr_r);
              state_r <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sck_fall) begin
            miso_r <= tx_r[15];
            tx_r   <= {tx_r[14:0], 1'b0};
          end
          if (sck_rise) begin
            rx_r <= {rx_r[14:0], mosi_s2_r};
            if (bit_cnt_r == `SER_LAST_BIT) begin
              state_r <= ST_IDLE;
            end else begin
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign spi_miso    = miso_r;
  assign spi_miso_oe = ~ss_s2_r & (state_r == ST_DATA) & ~wr_r;

  // register writes, committed on the last data bit
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      frp_ctx2_r       <= `RST_FRAME_OR_RESET_PERIOD_CTX2;
      int_ctx2_r       <= `RST_INTEGRATION_TIME_CTX2;
      gain_ctx2_r      <= `RST_ANALOG_GAIN_CTX2;
      post_gain_ctx2_r <= `RST_POST_ADC_GAIN_CTX2;
      spare_e9_r       <= `RST_SPARE_E9;
      spare_ea_r       <= `RST_SPARE_EA;
      spare_ed_r       <= `RST_SPARE_ED;
      spare_ee_r       <= `RST_SPARE_EE;
      spare_ef_r       <= `RST_SPARE_EF;
    end else if (frame_end && wr_r) begin
      case (addr_r)
        `ADDR_FRAME_OR_RESET_PERIOD_CTX2: frp_ctx2_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_INTEGRATION_TIME_CTX2:      int_ctx2_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_SPARE_E9:                   spare_e9_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_SPARE_EA:                   spare_ea_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_ANALOG_GAIN_CTX2:           gain_ctx2_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_POST_ADC_GAIN_CTX2:         post_gain_ctx2_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_SPARE_ED:                   spare_ed_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_SPARE_EE:                   spare_ee_r <= {rx_r[14:0], mosi_s2_r};
        `ADDR_SPARE_EF:                   spare_ef_r <= {rx_r[14:0], mosi_s2_r};
        default: begin
        end
      endcase
    end
  end

  // status capture from the sequencer
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tu_stat_r   <= `RST_STATUS;
      rp_stat_r   <= `RST_STATUS;
      it_stat_r   <= `RST_STATUS;
      itb_stat_r  <= `RST_STATUS;
      itc_stat_r  <= `RST_STATUS;
      gain_stat_r <= 13'h0000;
    end else begin
      if (master_mode && global_shutter) begin
        tu_stat_r <= time_unit_mult;
      end
      if (!slave_mode) begin
        rp_stat_r  <= seq_reset_period;
        it_stat_r  <= seq_integration_time;
        itb_stat_r <= seq_integration_time_b;
        itc_stat_r <= seq_integration_time_c;
      end
      gain_stat_r <= seq_analog_gain;
    end
  end

  // context fields to the sequencer
  assign frame_or_reset_period_ctx2 = frp_ctx2_r;
  assign integration_time_ctx2      = int_ctx2_r;
  assign column_amp_gain_ctx2       = gain_ctx2_r[`COL_GAIN_MSB:`COL_GAIN_LSB];
  assign frontend_amp_gain_ctx2     = gain_ctx2_r[`FE_GAIN_MSB:`FE_GAIN_LSB];
  assign post_adc_gain_ctx2         = post_gain_ctx2_r[`POST_ADC_GAIN_MSB:0];

  // zero multiplier treated as one unit per cycle
  assign mult_eff  = (time_unit_mult == 16'h0000) ? 16'h0001 : time_unit_mult;
  assign tmr_start = {integration_start, period_start};
  assign tmr_len   = {int_ctx2_r, frp_ctx2_r};

  // period meaning latched at start
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      period_mode_r <= `PERIOD_IS_RESET;
    end else if (period_start) begin
      period_mode_r <= period_select_mode;
    end
  end

  // unit-based timers: index 0 the period, index 1 the integration time
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : tmr
      reg  [15:0] unit_cnt_r;
      reg  [15:0] cnt_r;
      reg         busy_r;
      reg         done_r;
      wire [15:0] len;
      wire        unit_tick;
      assign len       = tmr_len[16*g+15:16*g];
      assign unit_tick = (unit_cnt_r + 16'h0001) >= mult_eff;
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          unit_cnt_r <= 16'h0000;
          cnt_r      <= 16'h0000;
          busy_r     <= 1'b0;
          done_r     <= 1'b0;
        end else begin
          done_r <= 1'b0;
          if (tmr_start[g]) begin
            unit_cnt_r <= 16'h0000;
            cnt_r      <= 16'h0000;
            busy_r     <= (len != 16'h0000);
            done_r     <= (len == 16'h0000);
          end else if (busy_r) begin
            if (unit_tick) begin
              unit_cnt_r <= 16'h0000;
              cnt_r      <= cnt_r + 16'h0001;
              if ((cnt_r + 16'h0001) == len) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
              end
            end else begin
              unit_cnt_r <= unit_cnt_r + 16'h0001;
            end
          end
        end
      end
      assign tmr_busy[g] = busy_r;
      assign tmr_done[g] = done_r;
    end
  endgenerate

  assign reset_period_end = tmr_done[0] & (period_mode_r == `PERIOD_IS_RESET);
  assign frame_period_end = tmr_done[0] & (period_mode_r == `PERIOD_IS_FRAME);
  assign period_busy      = tmr_busy[0];
  assign integration_busy = tmr_busy[1];
  assign integration_end  = tmr_done[1];

endmodule // exposure_gain_status_regs

`default_nettype wire

// [verif/exposure_gain_status_regs_props.sv]
// timer and default checks for the exposure context bank
// assumes binding onto the bank's top module ports
`timescale 1ns/10ps
`default_nettype none
module egsr_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // timer controls
  input wire logic        period_select_mode,
  input wire logic [15:0] time_unit_mult,
  input wire logic        period_start,
  input wire logic        integration_start,
  // context settings
  input wire logic [15:0] frame_or_reset_period_ctx2,
  input wire logic [15:0] integration_time_ctx2,
  input wire logic [4:0]  column_amp_gain_ctx2,
  input wire logic [7:0]  frontend_amp_gain_ctx2,
  input wire logic [11:0] post_adc_gain_ctx2,
  // timer results
  input wire logic        period_busy,
  input wire logic        reset_period_end,
  input wire logic        frame_period_end,
  input wire logic        integration_busy,
  input wire logic        integration_end
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // either period end
  wire any_end = reset_period_end | frame_period_end;
  // zero-length period start in a mode
  sequence s_zero(m);
    period_start && period_select_mode == m && frame_or_reset_period_ctx2 == 16'h0000;
  endsequence
  // three cycles of busy (one unit of three) then end
  sequence s_three;
    period_busy [*3] ##1 any_end;
  endsequence
  AST_RESET_END: assert property (s_zero(1'b0) |=> reset_period_end && !frame_period_end)
    else $error("reset period end missing");
  AST_FRAME_END: assert property (s_zero(1'b1) |=> frame_period_end && !reset_period_end)
    else $error("frame period end missing");
  AST_UNIT: assert property (period_start && frame_or_reset_period_ctx2 == 16'h0001 &&
    time_unit_mult == 16'h0003 |=> s_three) else $error("period of one unit wrong");
  AST_MULT0: assert property (period_start && frame_or_reset_period_ctx2 == 16'h0002 &&
    time_unit_mult == 16'h0000 |=> period_busy [*2] ##1 any_end) else $error("mult zero wrong");
  AST_INTEG: assert property (integration_start && integration_time_ctx2 == 16'h0002 &&
    time_unit_mult == 16'h0001 |=> integration_busy [*2] ##1 integration_end)
    else $error("integration length wrong");
  AST_RESET_VALS: assert property ($rose(rst_n) |-> integration_time_ctx2 == 16'h0000 &&
    frame_or_reset_period_ctx2 == 16'h0000 && post_adc_gain_ctx2 == 12'h080 &&
    column_amp_gain_ctx2 == 5'h03 && frontend_amp_gain_ctx2 == 8'h0F)
    else $error("context defaults wrong");
  AST_PEND_CAUSE: assert property (any_end |-> $past(period_busy) || $past(period_start))
    else $error("period end without timer");
  AST_IEND_CAUSE: assert property (integration_end |->
    $past(integration_busy) || $past(integration_start)) else $error("integration end stray");
endmodule // egsr_props
bind exposure_gain_status_regs egsr_props chk_u (.sys_clk, .rst_n, .period_select_mode,
  .time_unit_mult, .period_start, .integration_start, .frame_or_reset_period_ctx2,
  .integration_time_ctx2, .column_amp_gain_ctx2, .frontend_amp_gain_ctx2, .post_adc_gain_ctx2,
  .period_busy, .reset_period_end, .frame_period_end, .integration_busy, .integration_end);
`default_nettype wire

// [verif/spi_host_model.sv]
// host side of the serial configuration port: address, write bit, data
// assumes the bank samples its pins through two-flop synchronisers
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output var  logic spi_sck,
  output var  logic spi_ss_n,
  output var  logic spi_mosi,
  input  wire logic spi_miso
);
  // idle pins
  initial begin
    spi_sck = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one frame, msb first, 8-cycle sck phases
  task automatic xfer(input logic [8:0] a, input logic w, input logic [15:0] d,
                      output logic [15:0] q);
    logic [25:0] sh;
    sh = {a, w, d};
    q = 16'h0000;
    @(posedge sys_clk) #1 spi_ss_n = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      spi_mosi = sh[i];
      repeat (8) @(posedge sys_clk);
      #1 spi_sck = 1'b1;
      if (i < 16) q[i] = spi_miso; // read data taken on rise
      repeat (8) @(posedge sys_clk);
      #1 spi_sck = 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    #1 spi_ss_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale bit
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// [verif/exposure_gain_status_regs_test.sv]
// self-checking bench for the exposure context and status bank
// assumes the checker is bound in and the host model drives the pins
`timescale 1ns/10ps
`default_nettype none
module exposure_gain_status_regs_test;
  // stimulus
  logic sys_clk, rst_n, period_select_mode, master_mode, global_shutter, slave_mode;
  logic period_start, integration_start;
  logic [15:0] time_unit_mult, seq_reset_period, seq_integration_time;
  logic [15:0] seq_integration_time_b, seq_integration_time_c;
  logic [12:0] seq_analog_gain;
  // pins and results
  wire logic spi_sck, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe;
  wire logic period_busy, reset_period_end, frame_period_end, integration_busy, integration_end;
  wire logic [15:0] frame_or_reset_period_ctx2, integration_time_ctx2;
  wire logic [4:0]  column_amp_gain_ctx2;
  wire logic [7:0]  frontend_amp_gain_ctx2;
  wire logic [11:0] post_adc_gain_ctx2;
  int failures = 0;
  int check_count = 0;
  int oe_cycles = 0;
  // count cycles with miso driven
  always @(posedge sys_clk) if (spi_miso_oe) oe_cycles <= oe_cycles + 1;
  localparam logic [15:0] DEF [17] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01E3,
    16'h0080, 16'h0000, 16'hFFFF, 16'h0000, 16'h0050, 16'h1400, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // block and host
  exposure_gain_status_regs dut_u (.sys_clk, .rst_n, .spi_sck, .spi_ss_n, .spi_mosi,
    .spi_miso, .spi_miso_oe, .period_select_mode, .time_unit_mult, .master_mode,
    .global_shutter, .slave_mode, .period_start, .integration_start, .seq_reset_period,
    .seq_integration_time, .seq_integration_time_b, .seq_integration_time_c, .seq_analog_gain,
    .frame_or_reset_period_ctx2, .integration_time_ctx2, .column_amp_gain_ctx2,
    .frontend_amp_gain_ctx2, .post_adc_gain_ctx2, .period_busy, .reset_period_end,
    .frame_period_end, .integration_busy, .integration_end);
  spi_host_model host_u (.sys_clk, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso);
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] q;
    host_u.xfer(a, 1'b1, d, q);
  endtask
  task automatic rchk(input string nm, input logic [8:0] a, input logic [15:0] e);
    logic [15:0] q;
    host_u.xfer(a, 1'b0, 16'h0000, q);
    check(nm, e, q);
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic t_defaults;
    for (int i = 0; i < 17; i++)
      rchk("reset value", 9'h0E7 + i[8:0], DEF[i]);
    $display("test defaults done");
  endtask
  task automatic t_ro_write;
    for (int i = 9; i < 17; i++)
      wr(9'h0E7 + i[8:0], 16'hA5A5);
    wr(9'h0F8, 16'hA5A5);
    for (int i = 9; i < 17; i++)
      rchk("status after write", 9'h0E7 + i[8:0], DEF[i]);
    rchk("unmapped", 9'h0F8, 16'h0000);
    $display("test ro_write done");
  endtask
  task automatic t_ctx;
    int c0;
    c0 = oe_cycles;
    wr(9'h0E8, 16'h1234);
    check("oe in write", 16'h0000, oe_cycles[15:0] - c0[15:0]);
    check("integration port", 16'h1234, integration_time_ctx2);
    c0 = oe_cycles;
    rchk("integration reg", 9'h0E8, 16'h1234);
    check("oe in read", 16'h0001, {15'h0, oe_cycles > c0});
    $display("test ctx done");
  endtask
  task automatic t_status;
    tick;
    {master_mode, global_shutter, time_unit_mult} = {2'b11, 16'h0003};
    {seq_reset_period, seq_integration_time} = {16'h1111, 16'h2222};
    {seq_integration_time_b, seq_integration_time_c} = {16'h3333, 16'h4444};
    seq_analog_gain = 13'h1ABC;
    rchk("gain status", 9'h0F7, 16'h1ABC);
    rchk("time unit live", 9'h0F2, 16'h0003);
    rchk("reset live", 9'h0F3, 16'h1111);
    rchk("integ live", 9'h0F6, 16'h4444);
    tick;
    {global_shutter, slave_mode, time_unit_mult} = {2'b01, 16'h0005};
    {seq_reset_period, seq_integration_time} = {16'h5555, 16'h6666};
    {seq_integration_time_b, seq_integration_time_c} = {16'h7777, 16'h8888};
    rchk("time unit held", 9'h0F2, 16'h0003);
    rchk("reset held", 9'h0F3, 16'h1111);
    rchk("integ held", 9'h0F4, 16'h2222);
    rchk("integ b held", 9'h0F5, 16'h3333);
    rchk("integ c held", 9'h0F6, 16'h4444);
    tick;
    slave_mode = 1'b0;
    $display("test status done");
  endtask
  wire any_end_w = reset_period_end | frame_period_end;
  // pulse a start and count cycles to its end; end follows len*mult busy cycles, a zero mult counting as one
  task automatic run_timer(input logic integ, input logic [15:0] e, input string nm);
    int n;
    n = 1;
    tick;
    if (integ) integration_start = 1'b1;
    else period_start = 1'b1;
    tick;
    {integration_start, period_start} = 2'b00;
    while (n < 100 && (integ ? integration_end : any_end_w) !== 1'b1) begin
      tick;
      n++;
    end
    check(nm, e, n[15:0]);
    if (!integ) check("frame flag", {15'h0, period_select_mode}, {15'h0, frame_period_end});
  endtask
  task automatic t_timers;
    wr(9'h0E7, 16'h0000);
    period_select_mode = 1'b0;
    run_timer(1'b0, 16'h0001, "reset mode end");
    period_select_mode = 1'b1;
    run_timer(1'b0, 16'h0001, "frame mode end");
    wr(9'h0E7, 16'h0001);
    time_unit_mult = 16'h0003;
    run_timer(1'b0, 16'h0004, "unit of three");
    wr(9'h0E7, 16'h0002);
    time_unit_mult = 16'h0000;
    run_timer(1'b0, 16'h0003, "mult zero");
    wr(9'h0E8, 16'h0002);
    time_unit_mult = 16'h0001;
    run_timer(1'b1, 16'h0003, "integration");
    $display("test timers done");
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    $display("ERROR watchdog expected done got hang");
    summarize;
  end
  // main sequence
  initial begin
    {rst_n, period_select_mode, master_mode, global_shutter, slave_mode} = 5'b00000;
    {period_start, integration_start, time_unit_mult} = {2'b00, 16'h0001};
    {seq_reset_period, seq_integration_time, seq_analog_gain} = {32'h0, 13'h0};
    {seq_integration_time_b, seq_integration_time_c} = 32'h0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_defaults;
    t_ro_write;
    t_ctx;
    t_status;
    t_timers;
    summarize;
  end
endmodule // exposure_gain_status_regs_test
`default_nettype wire
